/* File: shared/kbc_cfg.svh */
// constants for the keyboard controller status, alternate reset and a20 block
// assumes a 20 MHz clock and byte-wide isa i/o accesses
`ifndef KBC_CFG_SVH
`define KBC_CFG_SVH
`define IO_DATA_PORT      8'h60
`define IO_CMD_PORT       8'h64
`define IO_ALT_PORT       8'h92
`define ST_OUT_FULL       0
`define ST_IN_FULL        1
`define ST_CMD_DATA       3
`define ST_RESET          8'h00
`define ALT_READ_FIXED    8'h24
`define ALT_READ_MASK     8'h03
`define ALT_BIT_RST       0
`define ALT_BIT_A20       1
`define CFG_BIT_KRST_HW   0
`define CFG_BIT_A20_HW    1
`define CFG_BIT_ALT_EN    2
`define CMD_SET_A20       8'hD1
`define CMD_PULSE_RST     8'hFE
`define CMD_NOP           8'hFF
`define ADDR_BIT_CD       2
`define CLK_MHZ           20
`define RST_DELAY_US      14
`define RST_WIDTH_US      6
`define RST_DELAY_CYC     (`RST_DELAY_US * `CLK_MHZ)
`define RST_WIDTH_CYC     (`RST_WIDTH_US * `CLK_MHZ)
`define TIMER_W           9
`endif

/* File: shared/kbc_pkg.sv */
// types shared by the keyboard controller status block
// assumes kbc_cfg.svh is on the include path
package kbc_pkg;
  typedef enum logic [2:0] {
    PLS_IDLE  = 3'b001,
    PLS_DELAY = 3'b010,
    PLS_LOW   = 3'b100
  } pulse_state_e;
  typedef logic [7:0] byte_t;
endpackage : kbc_pkg

/* File: design/reset_pulse_gen.sv */
// delayed low-going reset pulse generator
// assumes a synchronous active-high reset and a one-cycle trigger
`timescale 1ns/1ns
`include "kbc_cfg.svh"
module reset_pulse_gen (
  // clock and reset
  input  wire logic CLK,
  input  wire logic RST,
  // trigger
  input  wire logic fire,
  // pulse, low while active
  output logic      pulse_n
);
  import kbc_pkg::*;
  typedef struct packed {
    pulse_state_e            st;
    logic [`TIMER_W-1:0]     cnt;
    logic                    out_n;
  } pls_s;
  pls_s s_r;
  pls_s s_nxt;
  always_comb begin
    s_nxt = s_r;
    unique case (s_r.st)
      PLS_IDLE: begin
        if (fire) begin
          s_nxt.st  = PLS_DELAY;
          s_nxt.cnt = `TIMER_W'(`RST_DELAY_CYC - 1);
        end
      end
      PLS_DELAY: begin
        if (s_r.cnt == '0) begin
          s_nxt.st    = PLS_LOW;
          s_nxt.cnt   = `TIMER_W'(`RST_WIDTH_CYC - 1);
          s_nxt.out_n = 1'b0;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      PLS_LOW: begin
        if (s_r.cnt == '0) begin
          s_nxt.st    = PLS_IDLE;
          s_nxt.out_n = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end
      end
      default: begin
        s_nxt.st    = PLS_IDLE;
        s_nxt.out_n = 1'b1;
      end
    endcase
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      s_r.st    <= PLS_IDLE;
      s_r.cnt   <= '0;
      s_r.out_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign pulse_n = s_r.out_n;
endmodule : reset_pulse_gen

/* File: design/kbc_status_a20.sv */
// host mailbox status flags, alternate reset/a20 register and reset/a20 merging
// assumes host strobes are synchronous one-cycle pulses on CLK, core side likewise
`timescale 1ns/1ns
`include "kbc_cfg.svh"
module kbc_status_a20 (
  // clock and reset
  input  wire logic          CLK,
  input  wire logic          RST,
  // host i/o bus, strobes one cycle each
  input  wire logic [7:0]    HOST_ADDR,
  input  wire logic          HOST_WR,
  input  wire logic          HOST_RD,
  input  wire kbc_pkg::byte_t HOST_WDATA,
  output kbc_pkg::byte_t     HOST_RDATA,
  output logic               HOST_INPUT_BYTE,
  output logic               HOST_INPUT_VALID,
  // embedded core side
  input  wire logic          CORE_STATUS_WR,
  input  wire kbc_pkg::byte_t CORE_STATUS_WDATA,
  input  wire logic          CORE_INPUT_RD,
  input  wire logic          CORE_OUTPUT_WR,
  input  wire logic          CORE_KBD_RESET_N,
  input  wire logic          CONTROLLER_A20_PORT_BIT,
  output kbc_pkg::byte_t     CORE_STATUS_RDATA,
  output logic               CORE_INPUT_INTERRUPT,
  // configuration and polarity
  input  wire logic [2:0]    RESET_A20_CONFIG_BYTE,
  input  wire logic          KRST_POLARITY_INV,
  // system outputs
  output logic               KEYBOARD_RESET_PIN,
  output logic               CPU_A20_MASK,
  output logic               ALTERNATE_A20_SIGNAL
);
  import kbc_pkg::*;
  typedef struct packed {
    byte_t status;
    logic  alternate_a20_signal;
    logic  alt_rst;
    logic  d1_pending;
    logic  hw_a20;
    logic  hw_rst_n;
    byte_t rdata;
    logic  in_valid;
    logic  in_byte;
    logic  krst_pin;
    logic  a20_mask;
    logic  alt_fire;
    logic  hw_fire;
  } kbc_s;
  kbc_s s_r;
  kbc_s s_nxt;
  logic alt_pulse_n;
  logic hw_pulse_n;
  logic alt_en;
  logic a20_hw;
  logic krst_hw;
  logic wr_data;
  logic wr_cmd;
  logic wr_alt;
  logic rd_alt;
  logic kbd_rst_n;
  logic merged_n;
  assign alt_en  = RESET_A20_CONFIG_BYTE[`CFG_BIT_ALT_EN];
  assign a20_hw  = RESET_A20_CONFIG_BYTE[`CFG_BIT_A20_HW];
  assign krst_hw = RESET_A20_CONFIG_BYTE[`CFG_BIT_KRST_HW];
  assign wr_data = HOST_WR && (HOST_ADDR == `IO_DATA_PORT);
  assign wr_cmd  = HOST_WR && (HOST_ADDR == `IO_CMD_PORT);
  assign wr_alt  = HOST_WR && (HOST_ADDR == `IO_ALT_PORT) && alt_en;
  assign rd_alt  = HOST_RD && (HOST_ADDR == `IO_ALT_PORT) && alt_en;
  // firmware or hardware source, never both
  // hardware path also honours the reset latch loaded by a d1 data byte
  assign kbd_rst_n = krst_hw ? (hw_pulse_n & s_r.hw_rst_n) : CORE_KBD_RESET_N;
  assign merged_n  = alt_en ? (kbd_rst_n & alt_pulse_n) : kbd_rst_n;
  always_comb begin
    logic hw_seq;
    hw_seq = 1'b0;
    s_nxt = s_r;
    s_nxt.in_valid = 1'b0;
    s_nxt.alt_fire = 1'b0;
    s_nxt.hw_fire  = 1'b0;
    s_nxt.rdata    = 8'h00;
    // core status write first so hardware events below win over it; a core output write beats a data-port read
    if (CORE_STATUS_WR) begin
      s_nxt.status = CORE_STATUS_WDATA;
    end
    if (CORE_INPUT_RD) begin
      s_nxt.status[`ST_IN_FULL] = 1'b0;
    end
    if (HOST_RD && (HOST_ADDR == `IO_DATA_PORT)) begin
      s_nxt.status[`ST_OUT_FULL] = 1'b0;
    end
    if (CORE_OUTPUT_WR) begin
      s_nxt.status[`ST_OUT_FULL] = 1'b1;
    end
    if (wr_cmd) begin
      if (a20_hw && (HOST_WDATA == `CMD_SET_A20)) begin
        s_nxt.d1_pending = 1'b1;
        hw_seq = 1'b1;
      end else if (krst_hw && (HOST_WDATA == `CMD_PULSE_RST)) begin
        s_nxt.hw_fire    = 1'b1;
        s_nxt.d1_pending = 1'b0;
        hw_seq = 1'b1;
      end else if (a20_hw && (HOST_WDATA == `CMD_NOP)) begin
        // trailing no-op leaves d1_pending as it is; firmware never sees it
        hw_seq = 1'b1;
      end else begin
        s_nxt.d1_pending = 1'b0;
      end
    end
    if (wr_data && s_r.d1_pending) begin
      s_nxt.hw_a20     = HOST_WDATA[`ALT_BIT_A20];
      s_nxt.hw_rst_n   = HOST_WDATA[`ALT_BIT_RST];
      s_nxt.d1_pending = 1'b0;
      hw_seq = 1'b1;
    end
    if ((wr_cmd || wr_data) && !hw_seq) begin
      s_nxt.status[`ST_CMD_DATA] = wr_cmd;
      s_nxt.status[`ST_IN_FULL]  = 1'b1;
      s_nxt.in_valid = 1'b1;
      s_nxt.in_byte  = HOST_ADDR[`ADDR_BIT_CD];
    end
    if (wr_alt) begin
      s_nxt.alternate_a20_signal = HOST_WDATA[`ALT_BIT_A20];
      s_nxt.alt_rst = HOST_WDATA[`ALT_BIT_RST];
      // a pulse only on a 0 to 1 edge of the stored bit
      s_nxt.alt_fire = HOST_WDATA[`ALT_BIT_RST] && !s_r.alt_rst;
    end
    if (HOST_RD && (HOST_ADDR == `IO_CMD_PORT)) begin
      s_nxt.rdata = s_r.status;
    end else if (rd_alt) begin
      s_nxt.rdata = `ALT_READ_FIXED | {6'b0, s_r.alternate_a20_signal, s_r.alt_rst};
    end
    s_nxt.krst_pin = merged_n ^ KRST_POLARITY_INV;
    // a20 source: hardware latch or the controller port bit, ored with the alternate a20 signal when alt_en is set
    s_nxt.a20_mask = (a20_hw ? s_r.hw_a20 : CONTROLLER_A20_PORT_BIT)
                     | (alt_en & s_r.alternate_a20_signal);
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      s_r.status     <= `ST_RESET;
      s_r.alternate_a20_signal    <= 1'b0;
      s_r.alt_rst    <= 1'b0;
      s_r.d1_pending <= 1'b0;
      s_r.hw_a20     <= 1'b0;
      s_r.hw_rst_n   <= 1'b1;
      s_r.rdata      <= 8'h00;
      s_r.in_valid   <= 1'b0;
      s_r.in_byte    <= 1'b0;
      s_r.krst_pin   <= 1'b1;
      s_r.a20_mask   <= 1'b0;
      s_r.alt_fire   <= 1'b0;
      s_r.hw_fire    <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end
  // counters on CLK; 14 us and 6 us exact at 20 MHz
  reset_pulse_gen u_alt_pulse (
    .CLK     (CLK),
    .RST     (RST),
    .fire    (s_r.alt_fire),
    .pulse_n (alt_pulse_n)
  );
  reset_pulse_gen u_hw_pulse (
    .CLK     (CLK),
    .RST     (RST),
    .fire    (s_r.hw_fire),
    .pulse_n (hw_pulse_n)
  );
  assign HOST_RDATA           = s_r.rdata;
  assign HOST_INPUT_VALID     = s_r.in_valid;
  assign HOST_INPUT_BYTE      = s_r.in_byte;
  assign CORE_STATUS_RDATA    = s_r.status;
  assign CORE_INPUT_INTERRUPT = s_r.status[`ST_IN_FULL];
  assign KEYBOARD_RESET_PIN   = s_r.krst_pin;
  assign CPU_A20_MASK         = s_r.a20_mask;
  assign ALTERNATE_A20_SIGNAL = s_r.alternate_a20_signal;
endmodule : kbc_status_a20

/* File: sim/kbc_status_a20_properties.sv */
// checker on the top ports of the status flags, alternate register and a20 merge
// assumes binding to kbc_status_a20, normal pin polarity while a reset pulse runs
`timescale 1ns/1ns
module kbc_status_a20_properties (
  input wire logic           CLK, RST, HOST_WR, HOST_RD, CORE_STATUS_WR, CORE_INPUT_RD,
  input wire logic           CORE_OUTPUT_WR, CONTROLLER_A20_PORT_BIT, CORE_INPUT_INTERRUPT,
  input wire logic           KEYBOARD_RESET_PIN, CPU_A20_MASK, ALTERNATE_A20_SIGNAL,
  input wire logic [7:0]     HOST_ADDR,
  input wire logic [2:0]     RESET_A20_CONFIG_BYTE,
  input wire kbc_pkg::byte_t HOST_WDATA, HOST_RDATA, CORE_STATUS_RDATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire logic [2:0] cf  = RESET_A20_CONFIG_BYTE;
  wire logic       w92 = HOST_WR && HOST_ADDR == 8'h92 && cf[2];
  logic            alt0_r;
  // copy of the stored bit, so a repeated 1 is not taken for a trigger
  always_ff @(posedge CLK) alt0_r <= RST ? 1'b0 : (w92 ? HOST_WDATA[0] : alt0_r);
  sequence s_fire; w92 && HOST_WDATA[0] && !alt0_r; endsequence
  sequence s_low; (!KEYBOARD_RESET_PIN) [*8]; endsequence
  AST_RDATA_IDLE: assert property (!HOST_RD |=> HOST_RDATA == 8'h00)
    else $error("read data not idle");
  AST_STATUS_RD: assert property (HOST_RD && HOST_ADDR == 8'h64
    |=> HOST_RDATA == $past(CORE_STATUS_RDATA)) else $error("status read wrong");
  AST_IN_SET: assert property (HOST_WR && (HOST_ADDR & 8'hFB) == 8'h60 && cf[1:0] == 2'b00
    |=> CORE_STATUS_RDATA[1] && CORE_STATUS_RDATA[3] == $past(HOST_ADDR[2]))
    else $error("host write flags wrong");
  AST_IN_CLR: assert property (CORE_INPUT_RD && !HOST_WR && !CORE_STATUS_WR
    |=> !CORE_STATUS_RDATA[1] && !CORE_INPUT_INTERRUPT) else $error("in-full not cleared");
  AST_OUT_SET: assert property (CORE_OUTPUT_WR && !CORE_STATUS_WR
    |=> CORE_STATUS_RDATA[0]) else $error("out-full not set");
  AST_OUT_CLR: assert property (HOST_RD && HOST_ADDR == 8'h60 && !CORE_OUTPUT_WR
    && !CORE_STATUS_WR |=> !CORE_STATUS_RDATA[0]) else $error("out-full not cleared");
  AST_ALT_RD: assert property (HOST_RD && HOST_ADDR == 8'h92
    |=> HOST_RDATA[7:2] == ($past(cf[2]) ? 6'h09 : 6'h00)) else $error("alt read wrong");
  AST_A20_OR: assert property (cf[2:1] == 2'b00
    |=> CPU_A20_MASK == $past(CONTROLLER_A20_PORT_BIT)) else $error("a20 mask wrong");
  AST_ALTERNATE_A20_SIGNAL: assert property (w92 |=> ALTERNATE_A20_SIGNAL == $past(HOST_WDATA[1]))
    else $error("alternate_a20_signal level wrong");
  AST_ALT_PULSE: assert property (s_fire |-> ##[270:290] s_low)
    else $error("alt reset pulse missing");
endmodule : kbc_status_a20_properties
bind kbc_status_a20 kbc_status_a20_properties u_props (.*);

/* File: sim/host_io_model.sv */
// host processor model making single-byte i/o cycles
// assumes the block takes a strobe on the rising edge where it is high
`timescale 1ns/1ns
module host_io_model (
  input  wire logic     CLK,
  output logic [7:0]    HOST_ADDR,
  output logic          HOST_WR,
  output logic          HOST_RD,
  output kbc_pkg::byte_t HOST_WDATA
);
  import kbc_pkg::*;
  initial {HOST_ADDR, HOST_WR, HOST_RD, HOST_WDATA} = 18'h0_0000;
  // released lines show the inverse so a stale value never passes
  task automatic cyc(input logic w, input logic [7:0] a, input byte_t d);
    @(posedge CLK);
    #1 {HOST_ADDR, HOST_WDATA, HOST_WR, HOST_RD} = {a, d, w, !w};
    @(posedge CLK);
    #1 {HOST_ADDR, HOST_WDATA, HOST_WR, HOST_RD} = {~a, ~d, 2'b00};
  endtask : cyc
endmodule : host_io_model

/* File: sim/kbc_status_a20_tb_top.sv */
// self-checking bench for the status flags, alternate register and a20 merge
// assumes host_io_model drives the host bus and the checker is bound
`timescale 1ns/1ns
module kbc_status_a20_tb_top;
  import kbc_pkg::*;
  logic CLK = 0, RST = 1, SWR = 0, IRD = 0, OWR = 0, KRN = 1, A20P = 0, INV = 0, rd_d = 0;
  logic [2:0] CFG = 3'b000;
  byte_t SWD = 8'h00, r, exp_q[$];
  wire logic [7:0] ADDR;
  wire logic WR, RD, IBYTE, IVALID, IINT, KPIN, MASK, ALTS;
  wire byte_t WD, RDATA, SRD;
  int bad_count = 0, n_tests = 0, n, w;
  always #25 CLK = ~CLK;
  host_io_model u_host (.CLK(CLK), .HOST_ADDR(ADDR), .HOST_WR(WR), .HOST_RD(RD), .HOST_WDATA(WD));
  kbc_status_a20 DUT (.CLK(CLK), .RST(RST), .HOST_ADDR(ADDR), .HOST_WR(WR), .HOST_RD(RD),
    .HOST_WDATA(WD), .HOST_RDATA(RDATA), .HOST_INPUT_BYTE(IBYTE), .HOST_INPUT_VALID(IVALID),
    .CORE_STATUS_WR(SWR), .CORE_STATUS_WDATA(SWD), .CORE_INPUT_RD(IRD), .CORE_OUTPUT_WR(OWR),
    .CORE_KBD_RESET_N(KRN), .CONTROLLER_A20_PORT_BIT(A20P), .CORE_STATUS_RDATA(SRD),
    .CORE_INPUT_INTERRUPT(IINT), .RESET_A20_CONFIG_BYTE(CFG), .KRST_POLARITY_INV(INV),
    .KEYBOARD_RESET_PIN(KPIN), .CPU_A20_MASK(MASK), .ALTERNATE_A20_SIGNAL(ALTS));
  task automatic chk(input logic ok);
    n_tests++;
    if (ok !== 1'b1) begin bad_count++; $display("[ERR] %0t output check failed", $time); end
  endtask : chk
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task automatic rd(input logic [7:0] a, input byte_t e);
    exp_q.push_back(e);
    u_host.cyc(0, a, 8'h00);
  endtask : rd
  task automatic core(input logic [2:0] m, input byte_t d);
    @(posedge CLK);
    #1 {SWR, IRD, OWR, SWD} = {m, d};
    @(posedge CLK);
    #1 {SWR, IRD, OWR} = 3'b000;
  endtask : core
  task automatic settle; repeat (3) @(posedge CLK); #1; endtask : settle
  // the bound on the first wait ends the run when an expected pulse never comes
  task automatic pulse_chk(input logic e);
    n = 0; w = 0;
    while (KPIN === 1'b1 && n < 400) begin @(posedge CLK); #1; n++; end
    while (KPIN === 1'b0 && w < 200) begin @(posedge CLK); #1; w++; end
    if (!e) chk(n == 400);
    else begin chk(n >= 276 && n <= 290 && w >= 118 && w <= 124); if (n == 400) end_sim; end
  endtask : pulse_chk
  // read answers stand one cycle; they are taken mid-cycle after the strobe
  always @(posedge CLK) rd_d <= RD;
  always @(negedge CLK) if (rd_d) begin
    n_tests++;
    if (exp_q.size() == 0 || RDATA !== exp_q[0]) begin
      bad_count++; $display("[ERR] %0t read data %h", $time, RDATA); end
    if (exp_q.size() != 0) void'(exp_q.pop_front());
  end
  initial begin
    void'($urandom(32'h2bf3));
    repeat (24) @(posedge CLK);
    #1 RST = 0;
    rd(8'h64, 8'h00);
    rd(8'h92, 8'h00);
    CFG = 3'b100;
    rd(8'h92, 8'h24);
    CFG = 3'b000; $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      u_host.cyc(1, i[0] ? 8'h64 : 8'h60, r);
      chk(IVALID === 1'b1 && IBYTE === i[0]);
      rd(8'h64, {4'h0, i[0], 3'b010});
      core(3'b010, 8'h00);
      rd(8'h64, {4'h0, i[0], 3'b000});
    end
    core(3'b001, 8'h00);
    rd(8'h64, 8'h09);
    rd(8'h60, 8'h00);
    rd(8'h64, 8'h08);
    r = $urandom;
    core(3'b100, r);
    rd(8'h64, r);
    core(3'b100, 8'h00); $display("test flags done");
    CFG = 3'b100;
    u_host.cyc(1, 8'h92, 8'h02); settle;
    chk(ALTS === 1'b1 && MASK === 1'b1);
    rd(8'h92, 8'h26);
    u_host.cyc(1, 8'h92, 8'h00);
    for (int i = 1; i >= 0; i--) begin A20P = i[0]; settle; chk(MASK === i[0]); end
    u_host.cyc(1, 8'h92, 8'h01); pulse_chk(1);
    u_host.cyc(1, 8'h92, 8'h01); pulse_chk(0);
    u_host.cyc(1, 8'h92, 8'h00);
    CFG = 3'b101; u_host.cyc(1, 8'h64, 8'hFE); pulse_chk(1);
    CFG = 3'b010; u_host.cyc(1, 8'h64, 8'hD1); u_host.cyc(1, 8'h60, 8'h03);
    chk(IVALID === 1'b0);
    u_host.cyc(1, 8'h64, 8'hFF); settle;
    chk(MASK === 1'b1 && SRD[1] === 1'b0 && IINT === 1'b0);
    CFG = 3'b000; KRN = 0; settle;
    chk(KPIN === 1'b0);
    INV = 1; settle;
    chk(KPIN === 1'b1);
    {KRN, INV} = 2'b10; $display("test reset and a20 done");
    end_sim;
  end
endmodule : kbc_status_a20_tb_top
